// [design/updown_threshold_counter.sv]
`timescale 1ns/1ps
module updown_threshold_counter
  import updown_threshold_counter_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Register bus
  input  wire apb_req_t    i_apb,
  output apb_rsp_t         o_apb,
  // Function inputs
  input  wire logic        i_pulse,
  input  wire logic        i_dir,
  input  wire logic        i_cnt_reset,
  input  wire logic        i_power_restore,
  // Live thresholds from other blocks
  input  wire logic [31:0] i_on_live,
  input  wire logic [31:0] i_off_live,
  // Function outputs
  output logic             o_q,
  output logic [31:0]      o_count
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0]  ctrl_q;           // Retain, on src, off src
  logic [31:0] initial_count_value_q; // Start value
  logic [31:0] on_thr_q;         // Configured on level
  logic [31:0] off_thr_q;        // Configured off level
  logic [15:0] scan_period_q;    // Scan cycle length
  logic [15:0] scan_cnt_q;       // Scan divider
  logic        scan_tick;        // One pulse per scan
  logic [31:0] count_q;          // Internal count
  logic        q_q;              // Switching output
  logic        pulse_prev_q;     // Last pulse level
  logic        limit_q;          // Sticky saturation flag
  logic        load_pulse;       // Software reload
  logic        reload;           // Any reload cause
  logic        cold_start;       // Restore without retain
  logic        rise;             // Pulse rising edge
  logic        at_limit;         // Step blocked
  logic [31:0] on_sel;           // Chosen on level
  logic [31:0] off_sel;          // Chosen off level
  logic        access;           // APB access phase
  logic        done;             // Transfer completes
  logic        wr_en;            // Write takes effect
  logic [31:0] rd_data;          // Read mux result
  apb_rsp_t    rsp_q;            // Registered answer

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // True for any offset that holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      CTRL_OFS, STATUS_OFS, COUNT_OFS, INIT_OFS,
      ON_OFS, OFF_OFS, SCAN_OFS: is_mapped = 1'b1;
      default:                   is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // True when a completing write targets offset a
  function automatic logic wr_hit(input logic en,
                                  input logic [7:0] pa,
                                  input logic [7:0] a);
    wr_hit = en && (pa == a);
  endfunction : wr_hit

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait state: pready rises on the second
  // access cycle, so all effects use one edge.
  assign access = i_apb.psel && i_apb.penable;
  assign done   = access && rsp_q.pready;
  assign wr_en  = done && i_apb.pwrite
                  && is_mapped(i_apb.paddr);

  // Answer register, data valid with pready
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsp_q <= '0;
    end else if (access && !rsp_q.pready) begin
      // Unmapped offsets answer with an error
      rsp_q.pready  <= 1'b1;
      rsp_q.prdata  <= rd_data;
      rsp_q.pslverr <= !is_mapped(i_apb.paddr);
    end else begin
      // Drop answer after the completing edge
      rsp_q <= '0;
    end
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (i_apb.paddr)
      CTRL_OFS: begin
        // Load bit is a strobe and reads zero
        rd_data[2:0] = ctrl_q;
      end
      STATUS_OFS: begin
        rd_data[STAT_Q_BIT]     = q_q;
        rd_data[STAT_RST_BIT]   = i_cnt_reset;
        rd_data[STAT_DIR_BIT]   = i_dir;
        rd_data[STAT_LIMIT_BIT] = limit_q;
      end
      COUNT_OFS: begin
        rd_data = count_q;
      end
      INIT_OFS: begin
        rd_data = initial_count_value_q;
      end
      ON_OFS: begin
        rd_data = on_sel;
      end
      OFF_OFS: begin
        rd_data = off_sel;
      end
      SCAN_OFS: begin
        rd_data[15:0] = scan_period_q;
      end
      default: begin
        // Unmapped reads return zero
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Control bits
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_hit(wr_en, i_apb.paddr, CTRL_OFS)) begin
      ctrl_q <= i_apb.pwdata[2:0];
    end
  end

  // Initial count value
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      initial_count_value_q <= INIT_RST;
    end else if (wr_hit(wr_en, i_apb.paddr, INIT_OFS)) begin
      initial_count_value_q <= i_apb.pwdata;
    end
  end

  // Configured thresholds
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      on_thr_q  <= ON_RST;
      off_thr_q <= OFF_RST;
    end else begin
      if (wr_hit(wr_en, i_apb.paddr, ON_OFS)) begin
        on_thr_q <= i_apb.pwdata;
      end
      if (wr_hit(wr_en, i_apb.paddr, OFF_OFS)) begin
        off_thr_q <= i_apb.pwdata;
      end
    end
  end

  // Scan period
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scan_period_q <= SCAN_RST;
    end else if (wr_hit(wr_en, i_apb.paddr, SCAN_OFS)) begin
      scan_period_q <= i_apb.pwdata[15:0];
    end
  end

  // Reload strobe from a control write
  assign load_pulse = wr_hit(wr_en, i_apb.paddr, CTRL_OFS)
                      && i_apb.pwdata[CTRL_LOAD_BIT];

  // ----------------------------------------
  // Threshold source selection
  // ----------------------------------------
  // Live values track the other block every cycle
  assign on_sel  = ctrl_q[CTRL_ON_SRC_BIT]
                   ? i_on_live : on_thr_q;
  assign off_sel = ctrl_q[CTRL_OFF_SRC_BIT]
                   ? i_off_live : off_thr_q;

  // ----------------------------------------
  // Scan cycle divider
  // ----------------------------------------
  // A period of zero or one gives a tick each cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scan_cnt_q <= 16'h0000;
    end else if (scan_tick) begin
      scan_cnt_q <= 16'h0000;
    end else begin
      scan_cnt_q <= scan_cnt_q + 16'h0001;
    end
  end

  assign scan_tick = (scan_cnt_q + 16'h0001)
                     >= scan_period_q;

  // ----------------------------------------
  // Pulse edge detection
  // ----------------------------------------
  // Edge history runs during the function reset too,
  // so a level already high at release is not a fresh edge.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= i_pulse;
    end
  end

  assign rise = i_pulse && !pulse_prev_q;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Power restore without retention is a cold start
  assign cold_start = i_power_restore
                      && !ctrl_q[CTRL_RETAIN_BIT];
  assign reload     = load_pulse || cold_start;
  // Saturate rather than wrap past the range ends
  assign at_limit   = i_dir ? (count_q == 32'h0000_0000)
                            : (count_q >= COUNT_MAX);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_q <= COUNT_RST;
    end else if (i_cnt_reset) begin
      // Held reset blocks every other cause
      count_q <= COUNT_RST;
    end else if (reload) begin
      count_q <= initial_count_value_q;
    end else if (rise && !at_limit) begin
      if (i_dir) begin
        count_q <= count_q - 32'h0000_0001;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // Sticky flag, a new hit wins over a clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      limit_q <= 1'b0;
    end else if (rise && at_limit && !i_cnt_reset
                 && !reload) begin
      limit_q <= 1'b1;
    end else if (wr_hit(wr_en, i_apb.paddr, STATUS_OFS)
                 && i_apb.pwdata[STAT_LIMIT_BIT]) begin
      limit_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Threshold evaluation
  // ----------------------------------------
  // Only sampled on scan ticks, so a count that
  // sweeps through a narrow window may be missed.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_q <= 1'b0;
    end else if (i_cnt_reset) begin
      q_q <= 1'b0;
    end else if (cold_start) begin
      q_q <= 1'b0;
    end else if (scan_tick) begin
      if (on_sel >= off_sel) begin
        // Hysteresis band
        if (count_q >= on_sel) begin
          q_q <= 1'b1;
        end else if (count_q < off_sel) begin
          q_q <= 1'b0;
        end else begin
          q_q <= q_q;
        end
      end else begin
        // Window band
        q_q <= (count_q >= on_sel)
               && (count_q < off_sel);
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All come from flip-flops
  assign o_q     = q_q;
  assign o_count = count_q;
  assign o_apb   = rsp_q;

endmodule : updown_threshold_counter

// [design/updown_threshold_counter_pkg.sv]
package updown_threshold_counter_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS  = 8'h08;
  localparam logic [7:0] INIT_OFS   = 8'h0C;
  localparam logic [7:0] ON_OFS     = 8'h10;
  localparam logic [7:0] OFF_OFS    = 8'h14;
  localparam logic [7:0] SCAN_OFS   = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // CTRL bits
  localparam int CTRL_RETAIN_BIT  = 0;
  localparam int CTRL_ON_SRC_BIT  = 1;
  localparam int CTRL_OFF_SRC_BIT = 2;
  localparam int CTRL_LOAD_BIT    = 3;
  // STATUS bits
  localparam int STAT_Q_BIT       = 0;
  localparam int STAT_RST_BIT     = 1;
  localparam int STAT_DIR_BIT     = 2;
  localparam int STAT_LIMIT_BIT   = 3;

  // ----------------------------------------
  // Values after reset and limits
  // ----------------------------------------
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [31:0] INIT_RST  = 32'h0000_0000;
  localparam logic [31:0] ON_RST    = 32'h0000_0000;
  localparam logic [31:0] OFF_RST   = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  // Highest count, 99999999 decimal
  localparam logic [31:0] COUNT_MAX = 32'h05F5_E0FF;

  // ----------------------------------------
  // Scan cycle timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCAN_TIME_NS  = 10000;
  localparam int SCAN_CYCLES   = SCAN_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] SCAN_RST = 16'(SCAN_CYCLES);

  // ----------------------------------------
  // Bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : updown_threshold_counter_pkg

// [tb/pulse_source.sv]
`timescale 1ns/1ps
module pulse_source (
  // Scan clock
  input  wire logic i_clk,
  // Terminal outputs
  output logic      o_pulse,
  output logic      o_dir
);
  // Terminals rest low, so the first edge is always a real rise
  initial begin
    o_pulse = 1'b0;
    o_dir   = 1'b0;
  end

  // Direction settles one clock before the first pulse
  task automatic burst(input int n, input logic d);
    @(posedge i_clk);
    o_dir <= d;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      o_pulse <= 1'b1;
      @(posedge i_clk);
      o_pulse <= 1'b0;
    end
  endtask : burst
endmodule : pulse_source

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import updown_threshold_counter_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  apb_req_t    apb    = '0;
  apb_rsp_t    rsp;
  logic        pulse;
  logic        dir;
  logic        crst   = 1'b0;
  logic        pr     = 1'b0;
  logic [31:0] on_l   = 32'h14;
  logic [31:0] off_l  = 32'hF;
  logic        q;
  logic [31:0] cnt;
  logic        err;
  int          n_mismatch   = 0;
  int          total_checks = 0;

  always #2.5 clk = ~clk;

  updown_threshold_counter i_updown_threshold_counter (
    .i_clk(clk), .i_arst_n(rst_n), .i_apb(apb), .o_apb(rsp),
    .i_pulse(pulse), .i_dir(dir), .i_cnt_reset(crst),
    .i_power_restore(pr), .i_on_live(on_l), .i_off_live(off_l),
    .o_q(q), .o_count(cnt));
  pulse_source i_pulse_source (.i_clk(clk), .o_pulse(pulse), .o_dir(dir));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One APB transfer; waits for ready, only the watchdog ends a dead wait
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  task automatic restore();
    @(posedge clk);
    pr <= 1'b1;
    @(posedge clk);
    pr <= 1'b0;
    tick(2);
  endtask : restore

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Short scan period keeps each twelve-cycle compare wait at three ticks
    wr(SCAN_OFS, 32'h4);
    wr(ON_OFS, 32'h5);
    wr(OFF_OFS, 32'h3);
    i_pulse_source.burst(6, 1'b0);
    tick(1);
    chk(cnt, 32'h6);
    rd(COUNT_OFS, 32'h6);
    tick(12);
    chk({31'h0, q}, 32'h1);
    i_pulse_source.burst(2, 1'b1);
    tick(12);
    chk({31'h0, q}, 32'h1);
    i_pulse_source.burst(2, 1'b1);
    tick(12);
    chk({31'h0, q}, 32'h0);
    wr(INIT_OFS, 32'hA);
    wr(CTRL_OFS, 32'h8);
    tick(1);
    chk(cnt, 32'hA);
    wr(ON_OFS, 32'h3);
    wr(OFF_OFS, 32'h8);
    tick(12);
    chk({31'h0, q}, 32'h0);
    i_pulse_source.burst(4, 1'b1);
    tick(12);
    chk({31'h0, q}, 32'h1);
    // Live thresholds 20 and 15 put count 6 below the band
    wr(CTRL_OFS, 32'h6);
    tick(12);
    chk({31'h0, q}, 32'h0);
    rd(ON_OFS, 32'h14);
    wr(CTRL_OFS, 32'h1);
    tick(12);
    restore();
    chk(cnt, 32'h6);
    chk({31'h0, q}, 32'h1);
    wr(CTRL_OFS, 32'h0);
    restore();
    chk(cnt, 32'hA);
    // Zero thresholds would set the output on every scan tick
    wr(ON_OFS, 32'h0);
    wr(OFF_OFS, 32'h0);
    tick(6);
    chk({31'h0, q}, 32'h1);
    // Held function reset swallows pulses and keeps the output low
    crst <= 1'b1;
    i_pulse_source.burst(3, 1'b0);
    tick(1);
    chk(cnt, 32'h0);
    chk({31'h0, q}, 32'h0);
    crst <= 1'b0;
    i_pulse_source.burst(1, 1'b1);
    tick(1);
    chk(cnt, 32'h0);
    // Status: output high, down direction, limit flag set by the blocked step
    rd(STATUS_OFS, 32'hD);
    // Writing one to the limit bit clears it
    wr(STATUS_OFS, 32'h8);
    rd(STATUS_OFS, 32'h5);
    rd(8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    print_verdict();
  end

  // Watchdog well beyond the sequence length of a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top

// [tb/utc_checker.sv]
`timescale 1ns/1ps
module utc_checker
  import updown_threshold_counter_pkg::*;
(
  // Clock, reset and bus
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire apb_req_t    i_apb,
  input wire apb_rsp_t    o_apb,
  // Function pins
  input wire logic        i_pulse,
  input wire logic        i_dir,
  input wire logic        i_cnt_reset,
  input wire logic        i_power_restore,
  input wire logic        o_q,
  input wire logic [31:0] o_count
);
  // Writes and restores may reload the count, so edges are excused then
  logic quiet;
  assign quiet = !(i_apb.psel && i_apb.pwrite) && !i_power_restore
                 && !i_cnt_reset;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  cnt_up_a: assert property (
    $rose(i_pulse) && !i_dir && quiet && o_count < COUNT_MAX
    |=> o_count == $past(o_count) + 32'h1) else $error("count up bad");
  cnt_dn_a: assert property (
    $rose(i_pulse) && i_dir && quiet && o_count > 32'h0
    |=> o_count == $past(o_count) - 32'h1) else $error("count dn bad");
  fall_hold_a: assert property (
    $fell(i_pulse) && quiet |=> $stable(o_count))
    else $error("falling edge counted");
  rst_clr_a: assert property (
    i_cnt_reset |=> o_count == 32'h0 && !o_q)
    else $error("reset did not clear");
  count_max_a: assert property (o_count <= COUNT_MAX)
    else $error("count past limit");

  // ----------------------------------------
  // Register bus answer
  // ----------------------------------------
  apb_lat_a: assert property (
    $rose(i_apb.penable) && i_apb.psel |-> !o_apb.pready ##1 o_apb.pready)
    else $error("ready late");
  apb_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready too long");
  rsp_idle_a: assert property (
    !o_apb.pready |-> o_apb.prdata == 32'h0 && !o_apb.pslverr)
    else $error("answer outside ready");
endmodule : utc_checker

bind updown_threshold_counter utc_checker i_utc_checker (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(i_apb), .o_apb(o_apb),
  .i_pulse(i_pulse), .i_dir(i_dir), .i_cnt_reset(i_cnt_reset),
  .i_power_restore(i_power_restore), .o_q(o_q), .o_count(o_count));
